// [logic/synth_cfg_defs.svh]
// Register offsets, field positions, reset values and timing counts for the config bank
`ifndef SYNTH_CFG_DEFS_SVH
`define SYNTH_CFG_DEFS_SVH
`define ADDR_PRODUCT_LETTER_A 8'h00
`define ADDR_PRODUCT_LETTER_B 8'h01
`define ADDR_SILICON_VERSION 8'h02
`define ADDR_VARIANT_TAG_A 8'h03
`define ADDR_VARIANT_TAG_B 8'h04
`define ADDR_OUTPUT_DIVIDER 8'h10
`define ADDR_FEEDBACK_INTEGER 8'h11
`define ADDR_FRACTION_HIGH 8'h12
`define ADDR_FRACTION_MID 8'h13
`define ADDR_FRACTION_LOW 8'h14
`define ADDR_CONTROL_PRIMARY 8'h15
`define ADDR_CONTROL_ALIAS 8'h50
`define ADDR_PULL_GAIN 8'h5A
`define BIT_OE_OVERRIDE 7
`define BIT_TUNING_OFF 3
`define BIT_FULL_RECAL 2
`define BIT_FINE_STEP 1
`define BIT_DEFAULTS_RELOAD 0
`define CONTROL_RESET 8'h00
`define CONTROL_MASK 8'h8F
`define DIVIDER_MASK 8'h0F
`define INTEGER_MASK 8'h3F
`define PULL_GAIN_MASK 8'h0F
`define RECAL_HALT_CYCLES 8'h10
`define RECAL_CAL_CYCLES 8'h20
`define FINE_SETTLE_CYCLES 8'h04
`define LOAD_CYCLES 8'h02
`endif

// [logic/synth_cfg_pkg.sv]
// Types shared by the synthesizer configuration bank
package synth_cfg_pkg;
    typedef enum logic [4:0] {
        SER_IDLE = 5'h01,
        SER_ADDR = 5'h02,
        SER_REG = 5'h04,
        SER_WRITE = 5'h08,
        SER_READ = 5'h10
    } ser_state_t;
    typedef enum logic [3:0] {
        UPD_LOAD = 4'h1,
        UPD_IDLE = 4'h2,
        UPD_HALT = 4'h4,
        UPD_FINE = 4'h8
    } upd_state_t;
endpackage : synth_cfg_pkg

// [logic/synth_i2c_config_regs.sv]
// I2C slave register bank of the clock synthesizer, with the PLL update sequencer
`timescale 1ns/1ps
`include "synth_cfg_defs.svh"

module synth_i2c_config_regs
    import synth_cfg_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h55,
    parameter logic [7:0] LETTER_A = 8'hA5, // Arbitrary value
    parameter logic [7:0] LETTER_B = 8'h5A, // Arbitrary value
    parameter logic [7:0] VERSION = 8'h3C, // Arbitrary value
    parameter logic [7:0] TAG_A = 8'hC3, // Arbitrary value
    parameter logic [6:0] TAG_B = 7'h2B, // Arbitrary value
    parameter logic [3:0] NV_DIVIDER = 4'hA,
    parameter logic [5:0] NV_INTEGER = 6'h19,
    parameter logic [23:0] NV_FRACTION = 24'h000000,
    parameter logic [3:0] NV_PULL_GAIN = 4'h5,
    parameter logic OE_ACTIVE_HIGH = 1'b1
)
(
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Serial link, SCL is the link clock
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Output enable pin
    input wire logic oe_pin,
    // PLL side
    output logic [3:0] pll_divider,
    output logic [5:0] pll_integer,
    output logic [23:0] pll_fraction,
    output logic pll_calibrate,
    output logic clock_halt,
    output logic [31:0] centre_setting,
    output logic output_enable,
    output logic tuning_enable,
    output logic [3:0] pull_gain
);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: START and STOP detection on SDA edges
    logic start_tog_r;
    logic stop_tog_r;
    logic busy_r;
    logic start_seen_r;

    // SDA falling with SCL high marks START; no SCL edge inside it
    always_ff @(negedge sda_in or posedge rst)
    begin
        if (rst)
            start_tog_r <= 1'b0;
        else if (scl_clk)
            start_tog_r <= ~start_tog_r;
    end

    // SDA rising with SCL high marks STOP
    always_ff @(posedge sda_in or posedge rst)
    begin
        if (rst)
            stop_tog_r <= 1'b0;
        else if (scl_clk)
            stop_tog_r <= ~stop_tog_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain: bit engine on SCL
    logic start_ack_r;
    logic stop_ack_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [7:0] ptr_r;
    logic ack_drive_r;
    logic ser_rd_r;
    ser_state_t ser_r;
    logic wr_tog_r;
    logic [7:0] wr_addr_r;
    logic [7:0] wr_data_r;
    logic [7:0] rd_data;
    logic sda_low_r;
    logic pending_start;
    logic bus_stop;
    assign pending_start = start_tog_r ^ start_ack_r;
    assign bus_stop = stop_tog_r ^ stop_ack_r;

    // Bus busy from START until STOP
    always_comb
        busy_r = start_seen_r & ~bus_stop;

    // Sample data on rising SCL
    always_ff @(posedge scl_clk or posedge rst)
    begin
        if (rst)
        begin
            start_ack_r <= 1'b0;
            stop_ack_r <= 1'b0;
            start_seen_r <= 1'b0;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            ser_r <= SER_IDLE;
            ser_rd_r <= 1'b0;
            wr_tog_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
        end
        else if (pending_start)
        begin
            // Any START restarts the engine at the first address bit
            start_ack_r <= start_tog_r;
            stop_ack_r <= stop_tog_r;
            start_seen_r <= 1'b1;
            ser_r <= SER_ADDR;
            bit_cnt_r <= 4'h1;
            shift_r <= {7'h00, sda_in};
        end
        else if (!busy_r | ser_r == SER_IDLE)
        begin
            stop_ack_r <= stop_tog_r;
            ser_r <= SER_IDLE;
            bit_cnt_r <= 4'h0;
        end
        else if (bit_cnt_r == 4'h8)
        begin
            // Ninth clock: acknowledge slot
            bit_cnt_r <= 4'h0;
            case (ser_r)
                SER_ADDR:
                    if (shift_r[7:1] != SLAVE_ADDR)
                        ser_r <= SER_IDLE;
                    else if (shift_r[0])
                    begin
                        ser_r <= SER_READ;
                        ser_rd_r <= 1'b1;
                    end
                    else
                    begin
                        ser_r <= SER_REG;
                        ser_rd_r <= 1'b0;
                    end
                SER_REG:
                begin
                    ptr_r <= shift_r;
                    ser_r <= SER_WRITE;
                end
                SER_WRITE:
                begin
                    wr_addr_r <= ptr_r;
                    wr_data_r <= shift_r;
                    wr_tog_r <= ~wr_tog_r;
                    ptr_r <= ptr_r + 8'h01;
                end
                SER_READ:
                begin
                    ptr_r <= ptr_r + 8'h01;
                    if (sda_in)
                        ser_r <= SER_IDLE;
                end
                default:
                    ser_r <= SER_IDLE;
            endcase
        end
        else
        begin
            shift_r <= {shift_r[6:0], sda_in};
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // Drive SDA on falling SCL: ACK after received bytes, data when reading
    always_ff @(negedge scl_clk or posedge rst)
    begin
        if (rst)
        begin
            sda_low_r <= 1'b0;
            tx_r <= 8'h00;
        end
        else if (pending_start | bus_stop)
            sda_low_r <= 1'b0;
        else if (bit_cnt_r == 4'h8 && ser_r != SER_READ)
            sda_low_r <= ser_r != SER_ADDR || shift_r[7:1] == SLAVE_ADDR;
        else if (ser_r == SER_READ && bit_cnt_r == 4'h0)
        begin
            tx_r <= {rd_data[6:0], 1'b0};
            sda_low_r <= ~rd_data[7];
        end
        else if (ser_r == SER_READ && bit_cnt_r < 4'h8)
        begin
            tx_r <= {tx_r[6:0], 1'b0};
            sda_low_r <= ~tx_r[7];
        end
        else
            sda_low_r <= 1'b0;
    end

    // Open drain: drive low only, release otherwise; SCL is never driven
    assign sda_out = 1'b0;
    assign sda_oe_n = ~sda_low_r;

    ////////////////////////////////////////////////////////////////////////
    // Core domain: write event crossing and register file
    logic [2:0] wr_sync_r;
    logic [7:0] divider_r;
    logic [7:0] integer_r;
    logic [23:0] fraction_r;
    logic [7:0] control_r;
    logic [7:0] pull_gain_r;
    logic wr_pulse;
    logic recal_done;
    logic fine_done;
    logic load_done;
    upd_state_t upd_r;
    logic [7:0] upd_cnt_r;
    logic [1:0] oe_sync_r;

    // Toggle crossing; first stage is read only by the second
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            wr_sync_r <= 3'h0;
        else
            wr_sync_r <= {wr_sync_r[1:0], wr_tog_r};
    end
    assign wr_pulse = wr_sync_r[2] ^ wr_sync_r[1];

    // Register write decode; the writes reading back differ only in masks
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            divider_r <= 8'h00;
            integer_r <= 8'h00;
            fraction_r <= 24'h000000;
            control_r <= `CONTROL_RESET;
            pull_gain_r <= 8'h00;
        end
        else
        begin
            if (upd_r == UPD_LOAD && upd_cnt_r == 8'h00)
            begin
                // Fetch power-up defaults into the user registers
                divider_r <= {4'h0, NV_DIVIDER};
                integer_r <= {2'h0, NV_INTEGER};
                fraction_r <= NV_FRACTION;
                pull_gain_r <= {4'h0, NV_PULL_GAIN};
            end
            if (wr_pulse)
            begin
                // Read-only codes at 0x00..0x04 fall through untouched
                if (wr_addr_r == `ADDR_OUTPUT_DIVIDER)
                    divider_r <= wr_data_r & `DIVIDER_MASK;
                else if (wr_addr_r == `ADDR_FEEDBACK_INTEGER)
                    integer_r <= wr_data_r & `INTEGER_MASK;
                else if (wr_addr_r == `ADDR_FRACTION_HIGH)
                    fraction_r[23:16] <= wr_data_r;
                else if (wr_addr_r == `ADDR_FRACTION_MID)
                    fraction_r[15:8] <= wr_data_r;
                else if (wr_addr_r == `ADDR_FRACTION_LOW)
                    fraction_r[7:0] <= wr_data_r;
                else if (wr_addr_r == `ADDR_PULL_GAIN)
                    pull_gain_r <= wr_data_r & `PULL_GAIN_MASK;
            end
            // Control: triggers are set-only by writes, cleared on completion
            if (wr_pulse && (wr_addr_r == `ADDR_CONTROL_PRIMARY ||
                wr_addr_r == `ADDR_CONTROL_ALIAS))
                control_r <= (wr_data_r & `CONTROL_MASK) |
                    (control_r & 8'h07 & ~{5'h00, recal_done, fine_done, load_done});
            else
                control_r <= control_r & ~{5'h00, recal_done, fine_done, load_done};
        end
    end

    // Readback mux into the link domain; data is static while a byte shifts
    always_comb
    begin
        if (ptr_r == `ADDR_PRODUCT_LETTER_A)
            rd_data = LETTER_A;
        else if (ptr_r == `ADDR_PRODUCT_LETTER_B)
            rd_data = LETTER_B;
        else if (ptr_r == `ADDR_SILICON_VERSION)
            rd_data = VERSION;
        else if (ptr_r == `ADDR_VARIANT_TAG_A)
            rd_data = TAG_A;
        else if (ptr_r == `ADDR_VARIANT_TAG_B)
            rd_data = {1'b0, TAG_B};
        else if (ptr_r == `ADDR_OUTPUT_DIVIDER)
            rd_data = divider_r;
        else if (ptr_r == `ADDR_FEEDBACK_INTEGER)
            rd_data = integer_r;
        else if (ptr_r == `ADDR_FRACTION_HIGH)
            rd_data = fraction_r[23:16];
        else if (ptr_r == `ADDR_FRACTION_MID)
            rd_data = fraction_r[15:8];
        else if (ptr_r == `ADDR_FRACTION_LOW)
            rd_data = fraction_r[7:0];
        else if (ptr_r == `ADDR_CONTROL_PRIMARY || ptr_r == `ADDR_CONTROL_ALIAS)
            rd_data = control_r;
        else if (ptr_r == `ADDR_PULL_GAIN)
            rd_data = pull_gain_r;
        else
            rd_data = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain: PLL update sequencer
    assign recal_done = upd_r == UPD_HALT && upd_cnt_r == 8'h00;
    assign fine_done = upd_r == UPD_FINE && upd_cnt_r == 8'h00;
    assign load_done = control_r[`BIT_DEFAULTS_RELOAD] && upd_r == UPD_IDLE;

    // Sequencer states
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            upd_r <= UPD_LOAD;
            upd_cnt_r <= `LOAD_CYCLES;
        end
        else
            case (upd_r)
                UPD_LOAD:
                    if (upd_cnt_r == 8'h00)
                    begin
                        upd_r <= UPD_HALT;
                        upd_cnt_r <= `RECAL_HALT_CYCLES + `RECAL_CAL_CYCLES;
                    end
                    else
                        upd_cnt_r <= upd_cnt_r - 8'h01;
                UPD_IDLE:
                    if (control_r[`BIT_FULL_RECAL])
                    begin
                        upd_r <= UPD_HALT;
                        upd_cnt_r <= `RECAL_HALT_CYCLES + `RECAL_CAL_CYCLES;
                    end
                    else if (control_r[`BIT_FINE_STEP])
                    begin
                        upd_r <= UPD_FINE;
                        upd_cnt_r <= `FINE_SETTLE_CYCLES;
                    end
                UPD_HALT, UPD_FINE:
                    if (upd_cnt_r == 8'h00)
                        upd_r <= UPD_IDLE;
                    else
                        upd_cnt_r <= upd_cnt_r - 8'h01;
                default:
                    upd_r <= UPD_IDLE;
            endcase
    end

    // PLL register loads; the fine step may pass straight to the new value
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pll_divider <= 4'h0;
            pll_integer <= 6'h00;
            pll_fraction <= 24'h000000;
            centre_setting <= 32'h00000000;
        end
        else if (recal_done)
        begin
            pll_divider <= divider_r[3:0];
            pll_integer <= integer_r[5:0];
            pll_fraction <= fraction_r;
            centre_setting <= {divider_r[3:0], integer_r[3:0], fraction_r};
        end
        else if (upd_r == UPD_IDLE && !control_r[`BIT_FULL_RECAL] &&
            control_r[`BIT_FINE_STEP])
        begin
            pll_integer <= integer_r[5:0];
            pll_fraction <= fraction_r;
        end
    end

    // Halt, calibration and buffer controls
    always_comb
    begin
        clock_halt = upd_r == UPD_HALT && upd_cnt_r > `RECAL_CAL_CYCLES;
        pll_calibrate = upd_r == UPD_HALT;
        output_enable = control_r[`BIT_OE_OVERRIDE] |
            (oe_sync_r[1] == OE_ACTIVE_HIGH);
        tuning_enable = ~control_r[`BIT_TUNING_OFF];
        pull_gain = pull_gain_r[3:0];
    end

    // Output enable pin synchroniser
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            oe_sync_r <= 2'h0;
        else
            oe_sync_r <= {oe_sync_r[0], oe_pin};
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_recal_begin;
        upd_r == UPD_IDLE && control_r[`BIT_FULL_RECAL];
    endsequence
    a_recal_halts: assert property (@(posedge core_clk) disable iff (rst)
        s_recal_begin |=> clock_halt) else $error("recal did not halt clock");
    a_recal_clears: assert property (@(posedge core_clk) disable iff (rst)
        s_recal_begin |-> ##[1:60] !control_r[`BIT_FULL_RECAL])
        else $error("recal trigger not cleared");
    a_fine_no_halt: assert property (@(posedge core_clk) disable iff (rst)
        upd_r == UPD_FINE |-> !clock_halt && !pll_calibrate)
        else $error("fine step halted clock");
    a_tuning_off: assert property (@(posedge core_clk) disable iff (rst)
        control_r[`BIT_TUNING_OFF] |-> !tuning_enable) else $error("tuning not off");
    a_oe_override: assert property (@(posedge core_clk) disable iff (rst)
        control_r[`BIT_OE_OVERRIDE] |-> output_enable) else $error("override ignored");
    a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
        pull_gain_r[7:4] == 4'h0 && control_r[6:4] == 3'h0) else $error("reserved set");
    a_centre_moves: assert property (@(posedge core_clk) disable iff (rst)
        recal_done |=> centre_setting[23:0] == $past(fraction_r))
        else $error("centre not adopted");
    a_start_resets: assert property (@(posedge scl_clk) disable iff (rst)
        pending_start |=> ser_r == SER_ADDR) else $error("start did not reset");
    a_ptr_steps: assert property (@(posedge scl_clk) disable iff (rst)
        !pending_start && !bus_stop && bit_cnt_r == 4'h8 && ser_r == SER_WRITE
        |=> ptr_r == $past(ptr_r) + 8'h01) else $error("pointer not advanced");

endmodule : synth_i2c_config_regs

// [dv/i2c_master_model.sv]
// Behavioural I2C bus master that drives SCL and shares the pulled-up SDA wire
`timescale 1ns/1ps
module i2c_master_model (
    // Bus lines seen by the device
    output logic scl_clk,
    output logic sda_wire,
    // Device SDA driver
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe_n
);
    logic sda_m;
    // Open-drain wire with pull-up: released lines read high
    assign sda_wire = sda_m & (dev_sda_oe_n | dev_sda_out);
    initial
    begin
        scl_clk = 1'b1;
        sda_m = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////////////////
    // SDA falls while SCL is high; also serves as repeated start
    task start();
        #1 sda_m = 1'b1;
        #2 scl_clk = 1'b1;
        #2 sda_m = 1'b0;
        #2 scl_clk = 1'b0;
    endtask : start
    // SDA rises while SCL is high; SCL then stands high
    task stop();
        #1 sda_m = 1'b0;
        #2 scl_clk = 1'b1;
        #2 sda_m = 1'b1;
        #3;
    endtask : stop
    // Send the top n bits, most significant first, SCL period 6 ns
    task bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--)
        begin
            #1 sda_m = b[i];
            #2 scl_clk = 1'b1;
            #3 scl_clk = 0;
        end
    endtask : bits
    // Byte out, then release SDA and sample the acknowledge; SCL pauses low afterwards
    task wr_byte(input logic [7:0] b, output logic ack);
        bits(b, 8);
        #1 sda_m = 1'b1;
        #2 scl_clk = 1'b1;
        #1 ack = ~sda_wire;
        #2 scl_clk = 1'b0;
        #500;
    endtask : wr_byte
    // Byte in, then acknowledge low, or release for not-acknowledge on the last byte
    task rd_byte(input logic last, output logic [7:0] b);
        for (int i = 0; i < 8; i++)
        begin
            #1 sda_m = 1'b1;
            #2 scl_clk = 1'b1;
            #1 b = {b[6:0], sda_wire};
            #2 scl_clk = 1'b0;
        end
        #1 sda_m = last;
        #2 scl_clk = 1'b1;
        #3 scl_clk = 1'b0;
        #1 sda_m = 1'b1;
        #500;
    endtask : rd_byte
endmodule : i2c_master_model

// [dv/synth_i2c_config_regs_test.sv]
// Self-checking testbench for the synthesizer configuration register bank
`timescale 1ns/1ps
module synth_i2c_config_regs_test;
    import synth_cfg_pkg::*;
    localparam logic [6:0] DEV = 7'h55;
    localparam logic [7:0] ID_A = 8'h5C; // Arbitrary value
    localparam logic [7:0] ID_B = 8'h6D; // Arbitrary value
    localparam logic [7:0] ID_V = 8'h27; // Arbitrary value
    localparam logic [7:0] ID_T = 8'h9E; // Arbitrary value
    localparam logic [6:0] ID_U = 7'h33; // Arbitrary value
    localparam logic [23:0] NV_FRAC = 24'h0ABCDE;
    logic core_clk, rst, oe_pin, scl_clk, sda_in, sda_out, sda_oe_n, ack;
    logic pll_calibrate, clock_halt, output_enable, tuning_enable;
    logic [3:0] pll_divider, pull_gain;
    logic [5:0] pll_integer;
    logic [23:0] pll_fraction;
    logic [31:0] centre_setting;
    logic [7:0] wd [8];
    logic [7:0] rd [8];
    int failures, num_checks, halt_cnt;
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Device, master model, clock, reset
    synth_i2c_config_regs #(.SLAVE_ADDR(DEV), .LETTER_A(ID_A), .LETTER_B(ID_B), .VERSION(ID_V),
        .TAG_A(ID_T), .TAG_B(ID_U), .NV_DIVIDER(4'hA), .NV_INTEGER(6'h19),
        .NV_FRACTION(NV_FRAC), .NV_PULL_GAIN(4'h5), .OE_ACTIVE_HIGH(1'b1)) u_dut (
        .core_clk(core_clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .oe_pin(oe_pin), .pll_divider(pll_divider),
        .pll_integer(pll_integer), .pll_fraction(pll_fraction), .pll_calibrate(pll_calibrate),
        .clock_halt(clock_halt), .centre_setting(centre_setting),
        .output_enable(output_enable), .tuning_enable(tuning_enable), .pull_gain(pull_gain));
    i2c_master_model u_master (.scl_clk(scl_clk), .sda_wire(sda_in), .dev_sda_out(sda_out),
        .dev_sda_oe_n(sda_oe_n));
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Count core cycles spent with the output clock halted
    always @(posedge core_clk) if (clock_halt === 1'b1) halt_cnt <= halt_cnt + 1;
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Comparison, closing report and bus transactions
    task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk
    task close_out();
        if (failures == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task wr_regs(input logic [7:0] addr, input int n);
        u_master.start();
        u_master.wr_byte({DEV, 1'b0}, ack);
        chk(ack, 1, "address ack");
        u_master.wr_byte(addr, ack);
        chk(ack, 1, "pointer ack");
        for (int i = 0; i < n; i++)
        begin
            u_master.wr_byte(wd[i], ack);
            chk(ack, 1, "data ack");
        end
        u_master.stop();
    endtask : wr_regs
    task rd_regs(input logic [7:0] addr, input int n);
        u_master.start();
        u_master.wr_byte({DEV, 1'b0}, ack);
        u_master.wr_byte(addr, ack);
        u_master.start();
        u_master.wr_byte({DEV, 1'b1}, ack);
        chk(ack, 1, "read address ack");
        for (int i = 0; i < n; i++) u_master.rd_byte(i == n - 1, rd[i]);
        u_master.stop();
    endtask : rd_regs
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_reset();
        repeat (60) @(posedge core_clk);
        chk({pll_divider, pll_integer, pll_fraction}, {4'hA, 6'h19, NV_FRAC}, "nv load");
        chk({pll_calibrate, tuning_enable}, 2'b01, "idle after load");
        rd_regs(8'h00, 5);
        chk({rd[0], rd[1], rd[2], rd[3]}, {ID_A, ID_B, ID_V, ID_T}, "ident");
        chk(rd[4], {1'b0, ID_U}, "variant b");
        rd_regs(8'h15, 1);
        chk(rd[0], 8'h00, "control reset");
        wd = '{default: 8'hFF};
        wr_regs(8'h00, 5);
        rd_regs(8'h00, 5);
        chk({rd[0], rd[1], rd[2], rd[3], rd[4]}, {ID_A, ID_B, ID_V, ID_T, 1'b0, ID_U}, "ro");
    endtask : t_reset
    task t_bulk();
        wd = '{8'h07, 8'h1C, 8'h12, 8'h34, 8'h56, 8'h00, 8'h00, 8'h00};
        wr_regs(8'h10, 5);
        rd_regs(8'h10, 5);
        chk({rd[0], rd[1], rd[2], rd[3], rd[4]}, 40'h071C123456, "bulk");
        chk(pll_integer, 6'h19, "pll untouched");
        u_master.start();
        u_master.wr_byte({7'h2A, 1'b0}, ack);
        chk(ack, 0, "foreign address");
        u_master.stop();
    endtask : t_bulk
    task t_fine();
        int base;
        base = halt_cnt;
        wd[0] = 8'h57;
        wd[1] = 8'h02;
        wr_regs(8'h14, 2);
        for (int i = 0; i < 50 && pll_fraction !== 24'h123457; i++) @(posedge core_clk);
        if (pll_fraction !== 24'h123457)
        begin
            failures++;
            close_out();
        end
        chk({pll_integer, pll_fraction}, 30'h1C123457, "fine load");
        chk({pll_divider, halt_cnt == base, pll_calibrate}, 6'h1E, "fine keeps clock");
        rd_regs(8'h15, 1);
        chk(rd[0], 8'h00, "fine self clear");
    endtask : t_fine
    task t_recal();
        int base;
        base = halt_cnt;
        wd[0] = 8'h04;
        wr_regs(8'h15, 1);
        wd[0] = 8'h00;
        wr_regs(8'h50, 1);
        repeat (4) @(posedge core_clk);
        chk(pll_calibrate, 1, "zero write keeps recal");
        for (int i = 0; i < 100 && pll_calibrate !== 1'b0; i++) @(posedge core_clk);
        if (pll_calibrate !== 1'b0)
        begin
            failures++;
            close_out();
        end
        chk({halt_cnt - base == 16, pll_divider}, 5'h17, "recal");
        chk(centre_setting, 32'h7C123456, "new centre");
        rd_regs(8'h50, 1);
        chk(rd[0], 8'h00, "recal self clear");
    endtask : t_recal
    task t_ctrl();
        oe_pin <= 1'b0;
        wd[0] = 8'h88;
        wr_regs(8'h15, 1);
        repeat (5) @(posedge core_clk);
        chk({output_enable, tuning_enable}, 2'b10, "override");
        wd[0] = 8'h00;
        wr_regs(8'h15, 1);
        repeat (5) @(posedge core_clk);
        chk({output_enable, tuning_enable}, 2'b01, "pin low");
        oe_pin <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk(output_enable, 1, "pin high");
        u_master.start();
        u_master.wr_byte({DEV, 1'b0}, ack);
        u_master.bits(8'h5A, 3);
        wd[0] = 8'h0B;
        wr_regs(8'h5A, 1);
        repeat (5) @(posedge core_clk);
        chk(pull_gain, 4'hB, "pull gain");
        rd_regs(8'h5A, 1);
        chk(rd[0], 8'h0B, "pull gain read");
    endtask : t_ctrl
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial
    begin
        rst = 1'b1;
        oe_pin = 1'b0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_bulk();
        t_recal();
        t_fine();
        t_ctrl();
        close_out();
    end
    initial
    begin
        #2000000;
        failures++;
        close_out();
    end
endmodule : synth_i2c_config_regs_test
